// >>> logic/shc_standby.sv
/*
  Standby halt controller: enters one of four low-power modes on a halt
  strobe, gates clocks, decides wake-up, applies warm-up after full stop.
  Assumes wake request levels are already resolved by the interrupt side,
  that cpu_irq_mask and halt_mode_select are steady at the halt strobe, and
  that raw pin requests arrive asynchronously.
*/
// Operation
// RL1: halt mode code selects one of four modes.
// RL2: CPU-only halt keeps clock and peripherals running.
// RL3: peripheral sleep clocks only a subset.
// RL4: oscillator sleep stops clock, clock pin high.
// RL5: full stop halts everything including oscillator.
// RL6: ports hold; deep modes halt peripherals; the code clears ports_hold in full stop.
// RL7: enabled interrupt above mask wakes and serviced.
// RL8: interrupt below mask keeps device halted.
// RL9: NMI always wakes and is serviced.
// RL10: masked external zero wakes without service.
// RL11: peripheral sleep ignores watchdog and converter.
// RL12: deep modes accept only NMI, external zero.
// RL13: full stop wake waits for warm-up.
// RL14: requests during entry held pending; the code latches them only in oscillator sleep and full stop.
// RL15: reset releases all modes; hold 3 ms.
// RL16: reset keeps RAM, initialises other settings.
// RL17: level external zero held until service.
// RL18: light modes sample on clock-out falling.
// RL19: oscillator sleep samples async, resumes sync.
// RL20: software disables watchdog before peripheral sleep.
// RL21: warm-up length chosen by warmup select.
// RL22: pins in full stop follow drive setting.
// RL23: mode latched at halt until wake.
module shc_standby
  import shc_pkg::*;
#(
  parameter int WARM_W = `SHC_WARM_CNT_W
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic halt_exec,
  input wire logic [1:0] halt_mode_select,
  input wire logic [2:0] cpu_irq_mask,
  input wire logic [1:0] warmup_select,
  input wire logic stop_pin_drive,
  input wire logic clkout_fall,
  input wire shc_wake_t wake_in,
  output shc_gate_t gate,
  output logic stop_pins_drive,
  output logic wake_pulse,
  output logic wake_service,
  output logic pending_flag,
  output logic [1:0] active_mode,
  output logic halted
);
  localparam int ENTRY_CLKS = `SHC_ENTRY_OSC_CLKS;
  localparam logic [WARM_W-1:0] WARM0 = WARM_W'(`SHC_WARM0);
  localparam logic [WARM_W-1:0] WARM1 = WARM_W'(`SHC_WARM1);
  localparam logic [WARM_W-1:0] WARM2 = WARM_W'(`SHC_WARM2);
  localparam logic [WARM_W-1:0] WARM3 = WARM_W'(`SHC_WARM3);

  typedef struct packed {
    shc_state_t st;
    logic [1:0] mode;
    logic [2:0] mask;
    logic [WARM_W-1:0] cnt;
    logic pend;
    logic pend_srv;
    logic srv;
    logic wake;
    shc_gate_t gate;
    logic pins;
    logic hlt;
    logic [7:0] sync1;
    logic [7:0] sync2;
  } shc_core_t;

  shc_core_t s_reg;
  shc_core_t s_next;
  logic deep;
  logic light;
  logic any_wake;
  logic any_srv;
  logic sample_ok;
  shc_wake_t w;

  // Wake qualification for the latched mode and mask.
  always_comb
  begin
    w = s_reg.sync2;
    deep = (s_reg.mode == `SHC_CODE_OSC) || (s_reg.mode == `SHC_CODE_STOP);
    light = !deep;
    // RL18 light-mode sampling
    // RL19 async sample resynchronised
    sample_ok = deep ? 1'b1 : clkout_fall;
    any_srv = 1'b0;
    any_wake = 1'b0;
    // RL9 NMI always wakes
    if (w.nmi)
    begin
      any_srv = 1'b1;
    end
    // RL7 above-mask service
    // RL12 deep-mode source filter
    if (w.ext0 && (w.level > s_reg.mask))
    begin
      any_srv = 1'b1;
    end
    // RL11 light-mode source set
    // RL8 below-mask ignored
    if (light && (w.level > s_reg.mask) && (w.other
        || (w.wdt && s_reg.mode == `SHC_CODE_RUN)
        || (w.adc && s_reg.mode == `SHC_CODE_RUN)))
    begin
      any_srv = 1'b1;
    end
    // RL10 masked ext zero wakes
    any_wake = any_srv || w.ext0;
  end

  // Next-state logic of the whole controller.
  always_comb
  begin
    s_next = s_reg;
    s_next.sync1 = wake_in;
    s_next.sync2 = s_reg.sync1;
    s_next.wake = 1'b0;
    s_next.pins = 1'b0;
    case (s_reg.st)
      SHC_ACTIVE:
      begin
        s_next.gate = '{cpu_run: 1'b1, sysclk_en: 1'b1, peri_clk_en: 1'b1,
          subset_clk_en: 1'b1, osc_en: 1'b1, ports_hold: 1'b0, clkout_high: 1'b0};
        if (halt_exec)
        begin
          // RL23 latch mode at halt
          s_next.mode = halt_mode_select;
          s_next.mask = cpu_irq_mask;
          s_next.cnt = '0;
          s_next.pend = 1'b0;
          s_next.st = SHC_ENTER;
          s_next.gate.cpu_run = 1'b0;
        end
      end
      SHC_ENTER:
      begin
        // RL14 entry window pending
        if ((s_reg.mode == `SHC_CODE_OSC || s_reg.mode == `SHC_CODE_STOP) && any_wake)
        begin
          s_next.pend = 1'b1;
          s_next.pend_srv = any_srv;
        end
        s_next.cnt = s_reg.cnt + WARM_W'(1);
        if (s_reg.mode == `SHC_CODE_RUN || s_reg.mode == `SHC_CODE_PERI
            || s_reg.cnt == WARM_W'(ENTRY_CLKS - 1))
        begin
          s_next.st = SHC_HALTED;
          s_next.cnt = '0;
          // RL1 mode decode
          case (s_reg.mode)
            // RL2 CPU-only halt
            `SHC_CODE_RUN:
              s_next.gate = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
            // RL3 subset clocking
            `SHC_CODE_PERI:
              s_next.gate = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
            // RL4 clock pin high
            // RL6 peripherals halted
            `SHC_CODE_OSC:
              s_next.gate = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
            // RL5 everything halted
            default:
              s_next.gate = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
          endcase
        end
      end
      SHC_HALTED:
      begin
        // RL22 stop pin drive
        s_next.pins = (s_reg.mode == `SHC_CODE_STOP) && stop_pin_drive;
        if ((any_wake && sample_ok) || s_reg.pend)
        begin
          s_next.srv = s_reg.pend ? (s_reg.pend_srv || any_srv) : any_srv;
          s_next.pend = 1'b0;
          if (s_reg.mode == `SHC_CODE_STOP)
          begin
            // RL21 warm-up select
            case (warmup_select)
              2'h0: s_next.cnt = WARM0;
              2'h1: s_next.cnt = WARM1;
              2'h2: s_next.cnt = WARM2;
              default: s_next.cnt = WARM3;
            endcase
            s_next.gate.osc_en = 1'b1;
            s_next.st = SHC_WARM;
          end
          else
          begin
            s_next.st = SHC_RESUME;
          end
        end
      end
      SHC_WARM:
      begin
        // RL13 warm-up before release
        s_next.pins = stop_pin_drive;
        s_next.cnt = s_reg.cnt - WARM_W'(1);
        if (s_reg.cnt == WARM_W'(1))
        begin
          s_next.st = SHC_RESUME;
        end
      end
      SHC_RESUME:
      begin
        s_next.gate = '{cpu_run: 1'b1, sysclk_en: 1'b1, peri_clk_en: 1'b1,
          subset_clk_en: 1'b1, osc_en: 1'b1, ports_hold: 1'b0, clkout_high: 1'b0};
        s_next.wake = 1'b1;
        s_next.st = SHC_ACTIVE;
      end
      default:
        s_next.st = SHC_ACTIVE;
    endcase
    // Halt status gets its own flop so the output is registered, not an inverter.
    s_next.hlt = !s_next.gate.cpu_run;
  end

  // State register; reset releases any mode and reinitialises settings.
  always_ff @(posedge clk)
  begin
    // RL15 reset releases standby
    // RL16 settings reinitialised
    if (reset)
    begin
      s_reg <= '0;
      s_reg.st <= SHC_ACTIVE;
      s_reg.gate <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign gate = s_reg.gate;
  assign stop_pins_drive = s_reg.pins;
  assign wake_pulse = s_reg.wake;
  assign wake_service = s_reg.srv;
  assign pending_flag = s_reg.pend;
  assign active_mode = s_reg.mode;
  assign halted = s_reg.hlt;

  property p_nmi_wake;
    @(posedge clk) disable iff (reset)
    (s_reg.st == SHC_HALTED && s_reg.mode != `SHC_CODE_STOP && s_reg.sync2[7]
      && (sample_ok)) |=> s_reg.st == SHC_RESUME ##1 wake_pulse && wake_service;
  endproperty
  a_nmi_wake: assert property (p_nmi_wake) else $error("NMI did not wake"); // RL9

  property p_mask_hold;
    @(posedge clk) disable iff (reset)
    (s_reg.st == SHC_HALTED && !s_reg.pend && s_reg.sync2[7:6] == 2'b00
      && s_reg.sync2[2:0] <= s_reg.mask) |=> s_reg.st == SHC_HALTED;
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("woke without source"); // RL8

  property p_ext0_nosrv;
    @(posedge clk) disable iff (reset)
    (s_reg.st == SHC_HALTED && s_reg.mode == `SHC_CODE_OSC && !s_reg.pend
      && s_reg.sync2[7:6] == 2'b01 && s_reg.sync2[2:0] <= s_reg.mask)
      |=> ##1 wake_pulse && !wake_service;
  endproperty
  a_ext0_nosrv: assert property (p_ext0_nosrv) else $error("masked ext0 serviced"); // RL10

  property p_clk_high;
    @(posedge clk) disable iff (reset)
    (s_reg.st == SHC_HALTED && s_reg.mode == `SHC_CODE_OSC) |-> gate.clkout_high && !gate.sysclk_en;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("osc sleep clock wrong"); // RL4

  property p_stop_all;
    @(posedge clk) disable iff (reset)
    (s_reg.st == SHC_HALTED && s_reg.mode == `SHC_CODE_STOP) |-> !gate.osc_en && !gate.peri_clk_en;
  endproperty
  a_stop_all: assert property (p_stop_all) else $error("stop not halting"); // RL5

  property p_warm;
    @(posedge clk) disable iff (reset)
    $rose(s_reg.st == SHC_WARM) |-> !wake_pulse [*3];
  endproperty
  a_warm: assert property (p_warm) else $error("warm-up skipped"); // RL13

  property p_run_mode;
    @(posedge clk) disable iff (reset)
    (s_reg.st == SHC_HALTED && s_reg.mode == `SHC_CODE_RUN) |-> gate.sysclk_en && gate.peri_clk_en;
  endproperty
  a_run_mode: assert property (p_run_mode) else $error("run halt gating wrong"); // RL2

  property p_latch;
    @(posedge clk) disable iff (reset)
    (s_reg.st == SHC_ACTIVE && halt_exec) |=> active_mode == $past(halt_mode_select) && halted;
  endproperty
  a_latch: assert property (p_latch) else $error("mode not latched"); // RL23

  c_run: cover property (@(posedge clk) s_reg.st == SHC_HALTED && s_reg.mode == `SHC_CODE_RUN);
  c_stop_wake: cover property (@(posedge clk) s_reg.st == SHC_WARM ##[1:1000] wake_pulse);
  c_pend: cover property (@(posedge clk) pending_flag);
endmodule

// >>> logic/shc_map.svh
/*
  Constants of the standby halt controller: mode codes, reset hold time and timing counts.
  Assumes it is included by the package and the bench only.
*/
`ifndef SHC_MAP_SVH
`define SHC_MAP_SVH
`define SHC_CODE_RUN 2'h0
`define SHC_CODE_OSC 2'h2
`define SHC_CODE_STOP 2'h1
`define SHC_CODE_PERI 2'h3
`define SHC_CLK_NS 40
`define SHC_ENTRY_OSC_CLKS 3
`define SHC_WARM_CNT_W 16
`define SHC_WARM0 16'h0100
`define SHC_WARM1 16'h0400
`define SHC_WARM2 16'h1000
`define SHC_WARM3 16'h4000
`define SHC_RESET_MS 3
`define SHC_RESET_NS (`SHC_RESET_MS * 1000000)
`endif

// >>> logic/shc_pkg.sv
/*
  Types of the standby halt controller.
  Assumes the constants header sits beside it.
*/
`include "shc_map.svh"
package shc_pkg;
  typedef enum logic [2:0] {SHC_ACTIVE, SHC_ENTER, SHC_HALTED, SHC_WARM, SHC_RESUME} shc_state_t;

  // Wake request inputs from the interrupt side.
  typedef struct packed {
    logic nmi;
    logic ext0;
    logic wdt;
    logic adc;
    logic other;
    logic [2:0] level;
  } shc_wake_t;

  // Gating outputs towards clock tree and blocks.
  typedef struct packed {
    logic cpu_run;
    logic sysclk_en;
    logic peri_clk_en;
    logic subset_clk_en;
    logic osc_en;
    logic ports_hold;
    logic clkout_high;
  } shc_gate_t;
endpackage

// >>> tb/shc_irq_model.sv
/*
  Model of the interrupt side facing the standby controller: wake requests and
  clock-out falling marks.
  Assumes the bench fires one request at a time and resets between cases.
*/
module shc_irq_model
  import shc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic fire,
  input wire logic [2:0] kind,
  input wire logic [2:0] lvl,
  input wire logic wake_pulse,
  output shc_wake_t wake_in,
  output logic clkout_fall
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hold_reg;
  logic ph_reg;
  logic [2:0] kind_reg;
  logic [2:0] lvl_reg;
  logic [2:0] idle_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hold_reg <= 1'b0;
      ph_reg <= 1'b0;
      idle_reg <= 3'h0;
    end
    else
    begin
      ph_reg <= ~ph_reg;
      idle_reg <= idle_reg + 3'h1;
      if (fire)
      begin
        hold_reg <= 1'b1;
        kind_reg <= kind;
        lvl_reg <= lvl;
      end
      else if (wake_pulse)
        hold_reg <= 1'b0;
    end
  end

  assign clkout_fall = ph_reg;

  // The level field wanders when no request is held, so no stale value can match.
  always_comb
  begin
    wake_in.nmi = hold_reg && kind_reg == 3'h1;
    wake_in.ext0 = hold_reg && kind_reg == 3'h2;
    wake_in.wdt = hold_reg && kind_reg == 3'h3;
    wake_in.adc = hold_reg && kind_reg == 3'h4;
    wake_in.other = hold_reg && kind_reg == 3'h5;
    wake_in.level = hold_reg ? lvl_reg : idle_reg;
  end
endmodule

// >>> tb/tb_shc_standby.sv
/*
  Self-checking bench of the standby controller: mode entry, wake rules, reset.
  Assumes the interrupt model beside it and the constants header on the path.
*/
`include "shc_map.svh"
module tb_shc_standby
  import shc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, halt_exec, stop_pin_drive, fire;
  logic clkout_fall, stop_pins_drive, wake_pulse, wake_service, pending_flag, halted;
  logic [1:0] halt_mode_select, warmup_select, active_mode;
  logic [2:0] cpu_irq_mask, kind, lvl;
  shc_wake_t wake_in;
  shc_gate_t gate;
  int n_errors = 0;
  int samples_checked = 0;

  shc_standby u_shc_standby (.clk(clk), .reset(reset), .halt_exec(halt_exec),
    .halt_mode_select(halt_mode_select), .cpu_irq_mask(cpu_irq_mask),
    .warmup_select(warmup_select), .stop_pin_drive(stop_pin_drive),
    .clkout_fall(clkout_fall), .wake_in(wake_in), .gate(gate),
    .stop_pins_drive(stop_pins_drive), .wake_pulse(wake_pulse),
    .wake_service(wake_service), .pending_flag(pending_flag),
    .active_mode(active_mode), .halted(halted));

  shc_irq_model u_shc_irq_model (.clk(clk), .reset(reset), .fire(fire), .kind(kind),
    .lvl(lvl), .wake_pulse(wake_pulse), .wake_in(wake_in), .clkout_fall(clkout_fall));

  // Clock at 25 MHz.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compares one result and counts it.
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Reset, held long when leaving full stop, then the run state of every gate is checked.
  task automatic do_reset;
    logic long_rst;
    long_rst = (halted === 1'b1) && (active_mode === `SHC_CODE_STOP);
    @(posedge clk);
    reset <= 1'b1;
    if (long_rst)
      repeat (`SHC_RESET_NS / `SHC_CLK_NS) @(posedge clk);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    cmp(8'(gate), 8'h7C);
    cmp(8'(halted), 8'h00);
  endtask

  task automatic do_halt(input logic [1:0] m, input logic [2:0] mk);
    @(posedge clk);
    halt_mode_select <= m;
    cpu_irq_mask <= mk;
    halt_exec <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    @(posedge clk);
    #1;
    cmp(8'(halted), 8'h01);
  endtask

  // Fires an NMI with the halt strobe, so it lands inside the three-clock entry window of the deep modes.
  task automatic pend_case(input logic [1:0] m, input logic ex);
    int n;
    @(posedge clk);
    halt_mode_select <= m;
    cpu_irq_mask <= 3'h6;
    halt_exec <= 1'b1;
    kind <= 3'h1;
    lvl <= 3'h7;
    fire <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmp(8'(pending_flag), 8'(ex));
    for (n = 0; n < 40 && wake_pulse !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    cmp(8'(wake_pulse), 8'h01);
    cmp(8'(wake_service), 8'h01);
    do_reset();
  endtask

  // Enters one mode and checks the gates that the mode fixes.
  task automatic mode_case(input logic [1:0] m, input logic [6:0] mk, input logic [6:0] ex);
    do_halt(m, 3'h0);
    repeat (4) @(posedge clk);
    #1;
    cmp(8'(gate & mk), 8'(ex));
    cmp(8'(active_mode), 8'(m));
    do_reset();
  endtask

  // Halts, fires one request and judges whether and how the device wakes.
  task automatic wake_case(input logic [1:0] m, input logic [2:0] mk, input logic [2:0] k,
    input logic [2:0] l, input logic [1:0] ws, input logic ex, input logic svc);
    int n;
    int lo;
    lo = (m == `SHC_CODE_STOP) ? ((ws == 2'h0) ? `SHC_WARM0 : `SHC_WARM1) : 0;
    @(posedge clk);
    warmup_select <= ws;
    do_halt(m, mk);
    repeat (4) @(posedge clk);
    #1;
    if (m == `SHC_CODE_STOP)
      cmp(8'(stop_pins_drive), 8'h01);
    @(posedge clk);
    kind <= k;
    lvl <= l;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    #1;
    for (n = 0; n < lo + 40 && wake_pulse !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    cmp(8'(wake_pulse), 8'(ex));
    if (ex)
    begin
      cmp(8'(n >= lo), 8'h01);
      cmp(8'(wake_service), 8'(svc));
    end
    do_reset();
  endtask

  // Cuts a hang short.
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    reset = 1'b1;
    halt_exec = 1'b0;
    fire = 1'b0;
    stop_pin_drive = 1'b1;
    halt_mode_select = 2'h0;
    warmup_select = 2'h0;
    cpu_irq_mask = 3'h0;
    kind = 3'h0;
    lvl = 3'h0;
    repeat (16) @(posedge clk);
    do_reset();
    mode_case(`SHC_CODE_RUN, 7'h7E, 7'h3E);
    mode_case(`SHC_CODE_PERI, 7'h5E, 7'h0E);
    mode_case(`SHC_CODE_OSC, 7'h7F, 7'h07);
    mode_case(`SHC_CODE_STOP, 7'h7C, 7'h00);
    wake_case(`SHC_CODE_RUN, 3'h3, 3'h5, 3'h5, 2'h0, 1'b1, 1'b1);
    wake_case(`SHC_CODE_RUN, 3'h3, 3'h5, 3'h2, 2'h0, 1'b0, 1'b0);
    wake_case(`SHC_CODE_RUN, 3'h3, 3'h3, 3'h5, 2'h0, 1'b1, 1'b1);
    wake_case(`SHC_CODE_PERI, 3'h3, 3'h3, 3'h5, 2'h0, 1'b0, 1'b0);
    wake_case(`SHC_CODE_PERI, 3'h3, 3'h4, 3'h5, 2'h0, 1'b0, 1'b0);
    wake_case(`SHC_CODE_PERI, 3'h3, 3'h5, 3'h5, 2'h0, 1'b1, 1'b1);
    wake_case(`SHC_CODE_OSC, 3'h6, 3'h1, 3'h7, 2'h0, 1'b1, 1'b1);
    wake_case(`SHC_CODE_OSC, 3'h6, 3'h2, 3'h1, 2'h0, 1'b1, 1'b0);
    wake_case(`SHC_CODE_OSC, 3'h0, 3'h5, 3'h5, 2'h0, 1'b0, 1'b0);
    wake_case(`SHC_CODE_STOP, 3'h6, 3'h1, 3'h7, 2'h0, 1'b1, 1'b1);
    wake_case(`SHC_CODE_STOP, 3'h6, 3'h2, 3'h1, 2'h1, 1'b1, 1'b0);
    pend_case(`SHC_CODE_RUN, 1'b0);
    pend_case(`SHC_CODE_OSC, 1'b1);
    close_out();
  end
endmodule
